// >>> sim/slot_far_side.sv
// far-side model: slot card rails, gate ramp indications and the shared mode pin
`timescale 1ns/10ps
module slot_far_side import hp_slot_pkg::*; (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic gate_enable_i,
  input wire logic [7:0] ramp12_i,
  input wire logic [7:0] ramp5_i,
  input wire logic [7:0] drain_i,
  input wire logic card_m66_i,
  input wire logic pin_o_i,
  input wire logic pin_oen_i,
  output logic gate_12v_o,
  output logic gate_5v_3v_o,
  output logic supplies_low_o,
  output logic pin_level_o
);
  logic [7:0] on_cnt_r;
  logic [7:0] off_cnt_r;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || !gate_enable_i) begin
      on_cnt_r <= 8'h00;
    end else if (on_cnt_r != 8'hFF) begin
      on_cnt_r <= on_cnt_r + 8'h01;
    end
    if (!resetn_i) begin
      off_cnt_r <= 8'hFF;
    end else if (gate_enable_i) begin
      off_cnt_r <= 8'h00;
    end else if (off_cnt_r != 8'hFF) begin
      off_cnt_r <= off_cnt_r + 8'h01;
    end
  end
  // slow or prompt ramps are chosen by the bench through the delay inputs
  assign gate_12v_o = gate_enable_i && on_cnt_r >= ramp12_i;
  assign gate_5v_3v_o = gate_enable_i && on_cnt_r >= ramp5_i;
  // rails bleed down only some time after the gates are off
  assign supplies_low_o = !gate_enable_i && off_cnt_r >= drain_i;
  // open-drain wire: pull-up, card level when released
  assign pin_level_o = !pin_oen_i ? pin_o_i : card_m66_i;
endmodule : slot_far_side

// >>> sim/tb.sv
// self-checking bench for the slot signal logic
`timescale 1ns/10ps
module tb import hp_slot_pkg::*;;
  logic mclk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [ADDR_W-1:0] avs_address_i;
  logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, rd;
  logic system_power_good_i, direct_mode_strap_i, latch_clock_i, attention_direct_i;
  logic aux_power_switch_request_n_i, aux_overcurrent_i, attention_button_n_i, main_power_request_i;
  logic gate_12v_drive_high_i, gate_5v_3v_drive_high_i, supplies_below_low_i, main_overcurrent_i;
  logic digital_supply_on_i, presence_detect_second_i, speed_66_mode_pin_i, speed_66_mode_pin_o;
  logic [CAP_W-1:0] card_capability_sense_i;
  logic speed_66_mode_pin_oen_o, slot_attention_indicator_o, slot_attention_indicator_oen_o;
  logic slot_fault_out_o, slot_fault_out_oen_o, aux_fault_latch_o, aux_fault_latch_oen_o;
  logic aux_power_enable_o, main_power_gate_enable_o, slot_power_off_status_o;
  logic slot_clock_switch_enable_n_o, slot_reset_out_o, card_m66;
  logic [7:0] ramp12, ramp5, drain;
  int fails, n_checks, lvl, prs;
  hot_plug_slot_signal_logic i_dut (.mclk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .system_power_good_i, .direct_mode_strap_i,
    .latch_clock_i, .attention_direct_i, .aux_power_switch_request_n_i, .aux_overcurrent_i,
    .attention_button_n_i, .main_power_request_i, .gate_12v_drive_high_i, .gate_5v_3v_drive_high_i,
    .supplies_below_low_i, .main_overcurrent_i, .digital_supply_on_i, .presence_detect_second_i,
    .card_capability_sense_i, .speed_66_mode_pin_i, .speed_66_mode_pin_o, .speed_66_mode_pin_oen_o,
    .slot_attention_indicator_o, .slot_attention_indicator_oen_o, .slot_fault_out_o, .slot_fault_out_oen_o,
    .aux_fault_latch_o, .aux_fault_latch_oen_o, .aux_power_enable_o, .main_power_gate_enable_o,
    .slot_power_off_status_o, .slot_clock_switch_enable_n_o, .slot_reset_out_o);
  slot_far_side i_far (.mclk_i, .resetn_i, .gate_enable_i(main_power_gate_enable_o), .ramp12_i(ramp12),
    .ramp5_i(ramp5), .drain_i(drain), .card_m66_i(card_m66), .pin_o_i(speed_66_mode_pin_o),
    .pin_oen_i(speed_66_mode_pin_oen_o), .gate_12v_o(gate_12v_drive_high_i),
    .gate_5v_3v_o(gate_5v_3v_drive_high_i), .supplies_low_o(supplies_below_low_i),
    .pin_level_o(speed_66_mode_pin_i));
  initial begin
    mclk_i = 1'h0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  // one avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'h0 && n < 20) begin
      n++;
      @(posedge mclk_i);
    end
    if (n == 20) fails++;
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(posedge mclk_i);
  endtask : bus
  task automatic pg_up(input logic dir);
    system_power_good_i <= 1'h0;
    tick(2);
    direct_mode_strap_i <= dir;
    system_power_good_i <= 1'h1;
    tick(3);
  endtask : pg_up
  task automatic latch;
    latch_clock_i <= 1'h1;
    tick(1);
    latch_clock_i <= 1'h0;
    tick(3);
  endtask : latch
  task automatic wait_st(input logic v);
    int n;
    n = 0;
    while (slot_power_off_status_o !== v && n < 100) begin
      n++;
      tick(1);
    end
    if (n == 100) fails++;
  endtask : wait_st
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // the sequence needs well under 2000 cycles
  initial begin
    #20000;
    fails++;
    conclude();
  end
  initial begin
    {resetn_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, system_power_good_i,
     direct_mode_strap_i, latch_clock_i, attention_direct_i, aux_overcurrent_i, main_power_request_i,
     main_overcurrent_i, presence_detect_second_i, card_capability_sense_i, card_m66} = '0;
    {aux_power_switch_request_n_i, attention_button_n_i, digital_supply_on_i} = 3'h7;
    {ramp12, ramp5, drain} = {8'h03, 8'h08, 8'h02};
    fails = 0;
    n_checks = 0;
    lvl = $urandom(2);
    lvl = $urandom_range(4);
    prs = $urandom_range(1);
    tick(6);
    resetn_i <= 1'h1;
    tick(1);
    bus(1'h0, REG_CTRL_OFS, '0);
    chk("ctrl reset", CTRL_RESET_VAL, rd);
    bus(1'h0, 4'hC, '0);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 2; i++) begin
      aux_power_switch_request_n_i <= i[0];
      tick(1);
      chk("aux enable", !i[0], aux_power_enable_o);
    end
    presence_detect_second_i <= prs[0];
    card_m66 <= !prs[0];
    card_capability_sense_i <= CAP_W'((1 << lvl) - 1);
    pg_up(1'h0);
    chk("attn serial entry", 1'h1, slot_attention_indicator_oen_o);
    tick(3);
    bus(1'h0, REG_STATUS_OFS, '0);
    chk("mode serial", 1'h0, rd[ST_DIRECT_BIT]);
    chk("presence2", prs[0], rd[ST_PRSNT2_BIT]);
    chk("m66 input", !prs[0], rd[ST_M66_IN_BIT]);
    chk("cap serial", (1 << lvl) - 1, rd[ST_CAP_LSB +: CAP_W]);
    bus(1'h1, REG_CTRL_OFS, 32'h27);
    chk("clken before latch", 1'h1, slot_clock_switch_enable_n_o);
    chk("attn before latch", 1'h1, slot_attention_indicator_oen_o);
    latch;
    chk("attn latched", 1'h0, slot_attention_indicator_oen_o);
    chk("reset out", 1'h1, slot_reset_out_o);
    chk("clken latched", 1'h0, slot_clock_switch_enable_n_o);
    chk("m66 drive", 2'h0, {speed_66_mode_pin_oen_o, speed_66_mode_pin_i});
    bus(1'h1, REG_CTRL_OFS, 32'h01);
    latch;
    chk("clken no shift", 1'h0, slot_clock_switch_enable_n_o);
    chk("reset out low", 1'h0, slot_reset_out_o);
    attention_button_n_i <= 1'h0;
    tick(2);
    attention_button_n_i <= 1'h1;
    tick(4);
    bus(1'h0, REG_STATUS_OFS, '0);
    chk("button", 1'h1, rd[ST_BUTTON_BIT]);
    bus(1'h1, REG_BTN_CLR_OFS, 32'h02);
    bus(1'h0, REG_STATUS_OFS, '0);
    chk("button clr", 1'h0, rd[ST_BUTTON_BIT]);
    aux_power_switch_request_n_i <= 1'h0;
    tick(1);
    aux_overcurrent_i <= 1'h1;
    tick(1);
    aux_overcurrent_i <= 1'h0;
    tick(4);
    bus(1'h0, REG_STATUS_OFS, '0);
    chk("aux fault held", 1'h1, rd[ST_AUXFLT_BIT]);
    system_power_good_i <= 1'h0;
    tick(3);
    chk("attn aux fault", 1'h0, slot_attention_indicator_oen_o);
    aux_power_switch_request_n_i <= 1'h1;
    tick(3);
    chk("aux fault clr", 1'h1, slot_attention_indicator_oen_o);
    pg_up(1'h1);
    for (int i = 0; i < 2; i++) begin
      attention_direct_i <= !i[0];
      tick(3);
      chk("attn direct", i[0], slot_attention_indicator_oen_o);
    end
    for (int l = 0; l < CAP_LEVELS; l++) begin
      card_capability_sense_i <= CAP_W'((1 << l) - 1);
      tick(4);
      chk("cap bit3 pin", l == 4, slot_reset_out_o);
      bus(1'h0, REG_STATUS_OFS, '0);
      chk("cap level", (1 << l) - 1, rd[ST_CAP_LSB +: CAP_W]);
    end
    aux_power_switch_request_n_i <= 1'h0;
    digital_supply_on_i <= 1'h0;
    aux_overcurrent_i <= 1'h1;
    tick(1);
    aux_overcurrent_i <= 1'h0;
    tick(3);
    chk("aux pin supply off", 1'h0, aux_fault_latch_oen_o);
    digital_supply_on_i <= 1'h1;
    tick(3);
    chk("aux pin supply on", 2'h2, {aux_fault_latch_oen_o, slot_attention_indicator_oen_o});
    chk("fault pin aux", 1'h0, slot_fault_out_oen_o);
    chk("od drive levels", 3'h0, {slot_attention_indicator_o, slot_fault_out_o, aux_fault_latch_o});
    aux_power_switch_request_n_i <= 1'h1;
    tick(3);
    main_power_request_i <= 1'h1;
    tick(3);
    chk("gate on", 1'h1, main_power_gate_enable_o);
    tick(2);
    chk("one gate only", 3'h4, {gate_12v_drive_high_i, gate_5v_3v_drive_high_i, slot_power_off_status_o});
    wait_st(1'h1);
    chk("both gates", 3'h7, {gate_12v_drive_high_i, gate_5v_3v_drive_high_i, slot_power_off_status_o});
    main_overcurrent_i <= 1'h1;
    tick(1);
    main_overcurrent_i <= 1'h0;
    tick(3);
    chk("oc status", 1'h0, slot_power_off_status_o);
    tick(5);
    chk("fault held", 1'h0, slot_fault_out_oen_o);
    main_power_request_i <= 1'h0;
    tick(3);
    chk("fault clr", 1'h1, slot_fault_out_oen_o);
    drain <= 8'h28;
    main_power_request_i <= 1'h1;
    tick(2);
    wait_st(1'h1);
    main_power_request_i <= 1'h0;
    tick(10);
    chk("gate off", 1'h0, main_power_gate_enable_o);
    chk("drain status", 2'h2, {slot_power_off_status_o, supplies_below_low_i});
    wait_st(1'h0);
    chk("rails low", 1'h1, supplies_below_low_i);
    conclude();
  end
endmodule : tb

// >>> src/capability_classifier.sv
// five-level card capability classification from the sense converter
`timescale 1ns/10ps
module capability_classifier import hp_slot_pkg::*; #(
  parameter int LEVELS = CAP_LEVELS
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [LEVELS-2:0] sense_code_i,
  output logic [LEVELS-2:0] cap_state_o
);
  typedef struct packed {
    logic [LEVELS-2:0] state;
  } cap_s;
  cap_s r, n;
  logic [2:0] level;

  // a bubbled converter code is counted, then rebuilt as a clean thermometer
  function automatic logic [2:0] ones(input logic [LEVELS-2:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < LEVELS - 1; i++) c = c + {2'h0, v[i]};
    return c;
  endfunction : ones

  always_comb begin
    n = r;
    level = ones(sense_code_i);
    for (int k = 0; k < LEVELS - 1; k++) n.state[k] = (level > 3'(k));
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) r <= '0;
    else r <= n;
  end

  assign cap_state_o = r.state;
endmodule : capability_classifier

// >>> src/hot_plug_slot_signal_logic.sv
// per-slot hot-plug signal logic: mode strap, latch transfer, indicators, faults, register bus
`timescale 1ns/10ps
// How it works
// - serial mode entry clears attention indicator
// - power good: attention follows command or input
// - no power good: attention shows aux fault
// - low aux request enables aux power
// - aux request deasserted clears aux fault
// - serial button press sets status bit
// - direct request turns main power on/off
// - direct request removal clears main fault
// - 66 MHz pin input, open-drain once clocked
// - status rises after both gates high
// - over-current drives power status low
// - turn-off status low after supplies low
// - capability sense mapped to five levels
// - serial slot reset push-pull from latch
// - direct mode: reset pin shows capability bit3
// - serial presence bit two sampled to status
// - aux fault pin valid only supply off
// - mode strap captured at power good rise
// - serial latch clock edge copies shadow to outputs
// - clock enable changes only on shift-out or power good rise
// - direct fault pin shows aux or main fault
module hot_plug_slot_signal_logic import hp_slot_pkg::*; (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic system_power_good_i,
  input wire logic direct_mode_strap_i,
  input wire logic latch_clock_i,
  input wire logic attention_direct_i,
  input wire logic aux_power_switch_request_n_i,
  input wire logic aux_overcurrent_i,
  input wire logic attention_button_n_i,
  input wire logic main_power_request_i,
  input wire logic gate_12v_drive_high_i,
  input wire logic gate_5v_3v_drive_high_i,
  input wire logic supplies_below_low_i,
  input wire logic main_overcurrent_i,
  input wire logic digital_supply_on_i,
  input wire logic presence_detect_second_i,
  input wire logic [CAP_W-1:0] card_capability_sense_i,
  input wire logic speed_66_mode_pin_i,
  output logic speed_66_mode_pin_o,
  output logic speed_66_mode_pin_oen_o,
  output logic slot_attention_indicator_o,
  output logic slot_attention_indicator_oen_o,
  output logic slot_fault_out_o,
  output logic slot_fault_out_oen_o,
  output logic aux_fault_latch_o,
  output logic aux_fault_latch_oen_o,
  output logic aux_power_enable_o,
  output logic main_power_gate_enable_o,
  output logic slot_power_off_status_o,
  output logic slot_clock_switch_enable_n_o,
  output logic slot_reset_out_o
);
  typedef struct packed {
    logic pg_prev;
    logic lc_prev;
    logic direct;
    logic [CTRL_W-1:0] shadow;
    logic par_attn;
    logic par_rst_rel;
    logic par_clken;
    logic par_m66;
    logic par_power;
    logic aux_flt;
    logic button;
    logic prsnt2;
    logic m66_in;
    logic ack;
    logic [DATA_W-1:0] rdata;
  } slot_s;
  slot_s r, n;

  logic pg_rise;
  logic lc_rise;
  logic bus_req;
  logic wr_take;
  logic btn_clear;
  logic attn_on;
  logic fault_on;
  logic [CAP_W-1:0] cap_state;
  logic [DATA_W-1:0] status_word;

  slot_power_if pwr ();

  main_power_sequencer u_seq (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .pwr(pwr.seq)
  );

  capability_classifier #(
    .LEVELS(CAP_LEVELS)
  ) u_cap (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .sense_code_i(card_capability_sense_i),
    .cap_state_o(cap_state)
  );

  // main power is held off until power good; serial mode takes the latched bit
  assign pwr.request = system_power_good_i && (r.direct ? main_power_request_i : r.par_power);
  assign pwr.gate_12v_high = gate_12v_drive_high_i;
  assign pwr.gate_5v_3v_high = gate_5v_3v_drive_high_i;
  assign pwr.supplies_low = supplies_below_low_i;
  assign pwr.main_oc = main_overcurrent_i;
  assign pwr.aux_fault = r.aux_flt;

  assign pg_rise = system_power_good_i && !r.pg_prev;
  assign lc_rise = latch_clock_i && !r.lc_prev;
  assign bus_req = avs_read_i || avs_write_i;
  assign wr_take = avs_write_i && r.ack;
  assign btn_clear = wr_take && (avs_address_i == REG_BTN_CLR_OFS) && avs_writedata_i[ST_BUTTON_BIT];

  always_comb begin
    status_word = '0;
    status_word[ST_DIRECT_BIT] = r.direct;
    status_word[ST_BUTTON_BIT] = r.button;
    status_word[ST_PRSNT2_BIT] = r.prsnt2;
    status_word[ST_M66_IN_BIT] = r.m66_in;
    status_word[ST_AUXFLT_BIT] = r.aux_flt;
    status_word[ST_MAINFLT_BIT] = pwr.main_fault;
    status_word[ST_PWRSTAT_BIT] = pwr.power_status;
    status_word[ST_CLKEN_BIT] = r.par_clken;
    status_word[ST_CAP_LSB +: CAP_W] = cap_state;
  end

  always_comb begin
    n = r;
    n.pg_prev = system_power_good_i;
    n.lc_prev = latch_clock_i;
    if (pg_rise) begin
      n.direct = direct_mode_strap_i;
      // serial outputs start deasserted on every mode entry
      n.par_attn = 1'b0;
      n.par_rst_rel = 1'b0;
      n.par_clken = 1'b0;
      n.par_m66 = 1'b0;
      n.par_power = 1'b0;
    end else if (!r.direct && lc_rise) begin
      n.par_attn = r.shadow[CTRL_ATTN_BIT];
      n.par_rst_rel = r.shadow[CTRL_RST_REL_BIT];
      n.par_m66 = r.shadow[CTRL_M66_BIT];
      n.par_power = r.shadow[CTRL_POWER_BIT];
      if (r.shadow[CTRL_SHIFT_BIT]) begin
        n.par_clken = r.shadow[CTRL_CLKEN_BIT];
      end
    end
    // aux power is off while cleared, so a set cannot collide with the clear
    if (aux_power_switch_request_n_i) begin
      n.aux_flt = 1'b0;
    end else if (aux_overcurrent_i) begin
      n.aux_flt = 1'b1;
    end
    if (btn_clear) begin
      n.button = 1'b0;
    end
    // a press in the clearing cycle still sets the bit
    if (!r.direct && !attention_button_n_i) begin
      n.button = 1'b1;
    end
    if (!r.direct) begin
      n.prsnt2 = presence_detect_second_i;
      n.m66_in = speed_66_mode_pin_i;
    end
    n.ack = bus_req && !r.ack;
    if (avs_read_i && !r.ack) begin
      case (avs_address_i)
        REG_CTRL_OFS: n.rdata = {{(DATA_W - CTRL_W){1'b0}}, r.shadow};
        REG_STATUS_OFS: n.rdata = status_word;
        default: n.rdata = '0;
      endcase
    end
    if (wr_take && (avs_address_i == REG_CTRL_OFS)) begin
      n.shadow = avs_writedata_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.shadow <= CTRL_RESET_VAL;
    end else begin
      r <= n;
    end
  end

  // one wait state on every access
  assign avs_waitrequest_o = bus_req && !r.ack;
  assign avs_readdata_o = r.rdata;

  always_comb begin
    if (!system_power_good_i) begin
      attn_on = r.aux_flt;
    end else if (r.direct) begin
      // with the digital supply up the aux fault pin is invalid, so it shows here
      attn_on = attention_direct_i || (r.aux_flt && digital_supply_on_i);
    end else begin
      attn_on = r.par_attn;
    end
  end

  assign fault_on = r.direct && system_power_good_i && (r.aux_flt || pwr.main_fault);

  assign slot_attention_indicator_o = 1'b0;
  assign slot_attention_indicator_oen_o = !attn_on;
  assign slot_fault_out_o = 1'b0;
  assign slot_fault_out_oen_o = !fault_on;
  assign aux_fault_latch_o = 1'b0;
  assign aux_fault_latch_oen_o = !(r.direct && !digital_supply_on_i && r.aux_flt);
  assign aux_power_enable_o = !aux_power_switch_request_n_i;
  assign main_power_gate_enable_o = pwr.gate_enable;
  assign slot_power_off_status_o = pwr.power_status;
  assign slot_clock_switch_enable_n_o = !r.par_clken;
  assign slot_reset_out_o = r.direct ? cap_state[CAP_W-1] : r.par_rst_rel;
  // open-drain: only a low is ever driven onto the mode pin
  assign speed_66_mode_pin_o = 1'b0;
  assign speed_66_mode_pin_oen_o = !(!r.direct && r.par_clken && !r.par_m66);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_mode_capture: assert property (pg_rise |=> r.direct == $past(direct_mode_strap_i))
    else $error("mode strap not captured on power good rise");
  a_serial_default: assert property (pg_rise |=> !r.par_attn && !r.par_clken)
    else $error("serial outputs not cleared on mode entry");
  a_attn_no_pg: assert property (!system_power_good_i |-> slot_attention_indicator_oen_o == !r.aux_flt)
    else $error("attention does not show aux fault without power good");
  a_attn_serial: assert property (system_power_good_i && !r.direct |-> slot_attention_indicator_oen_o == !r.par_attn)
    else $error("attention does not follow latched command");
  a_aux_clear: assert property (aux_power_switch_request_n_i |-> !aux_power_enable_o ##1 !r.aux_flt)
    else $error("aux fault not cleared by request deassertion");
  a_aux_hold: assert property (r.aux_flt && !aux_power_switch_request_n_i |=> r.aux_flt)
    else $error("aux fault latch dropped while request held");
  a_button_set: assert property (!r.direct && !attention_button_n_i |=> r.button)
    else $error("button press not recorded");
  a_button_sticky: assert property (r.button && !btn_clear ##1 attention_button_n_i |-> r.button)
    else $error("button bit lost without a clear");
  a_latch_xfer: assert property (!r.direct && lc_rise && !pg_rise |=> r.par_attn == $past(r.shadow[CTRL_ATTN_BIT]))
    else $error("latch edge did not transfer attention bit");
  a_clken_stable: assert property (!pg_rise && !(lc_rise && !r.direct && r.shadow[CTRL_SHIFT_BIT]) |=> $stable(r.par_clken))
    else $error("clock enable changed without shift-out latch");
  a_m66_drive: assert property (!speed_66_mode_pin_oen_o |-> !r.direct && r.par_clken)
    else $error("mode pin driven without clock enable");
  a_reset_direct: assert property (r.direct |-> slot_reset_out_o == cap_state[CAP_W-1])
    else $error("reset pin does not show capability bit");
  a_fault_pin: assert property (r.direct && system_power_good_i && pwr.main_fault |-> !slot_fault_out_oen_o)
    else $error("fault pin not active on main fault");
  a_bus_answer: assert property (bus_req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus access not answered after one wait state");

  c_serial_latch: cover property (!r.direct && lc_rise && r.shadow[CTRL_SHIFT_BIT]);
  c_button_clear: cover property (r.button ##1 btn_clear ##1 !r.button);
  c_direct_fault: cover property (r.direct && fault_on);
endmodule : hot_plug_slot_signal_logic

// >>> src/hp_slot_pkg.sv
// constants, register map and types shared by the slot signal logic
package hp_slot_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int CAP_W = 4;
  localparam int CAP_LEVELS = 5;
  localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_BTN_CLR_OFS = 4'h8;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 6'h00;
  localparam int CTRL_ATTN_BIT = 0;
  localparam int CTRL_RST_REL_BIT = 1;
  localparam int CTRL_CLKEN_BIT = 2;
  localparam int CTRL_M66_BIT = 3;
  localparam int CTRL_POWER_BIT = 4;
  localparam int CTRL_SHIFT_BIT = 5;
  localparam int ST_DIRECT_BIT = 0;
  localparam int ST_BUTTON_BIT = 1;
  localparam int ST_PRSNT2_BIT = 2;
  localparam int ST_M66_IN_BIT = 3;
  localparam int ST_AUXFLT_BIT = 4;
  localparam int ST_MAINFLT_BIT = 5;
  localparam int ST_PWRSTAT_BIT = 6;
  localparam int ST_CLKEN_BIT = 7;
  localparam int ST_CAP_LSB = 8;
  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_RAMP,
    PWR_ON,
    PWR_DRAIN,
    PWR_FAULT
  } pwr_state_e;
endpackage : hp_slot_pkg

// >>> src/main_power_sequencer.sv
// main power on/off sequencing, power status output and main fault latch
`timescale 1ns/10ps
module main_power_sequencer import hp_slot_pkg::*; (
  input wire logic mclk_i,
  input wire logic resetn_i,
  slot_power_if.seq pwr
);
  typedef struct packed {
    pwr_state_e st;
    logic status;
    logic fault;
  } seq_s;
  seq_s r, n;

  always_comb begin
    n = r;
    case (r.st)
      PWR_OFF: begin
        n.status = 1'b0;
        if (pwr.request) n.st = PWR_RAMP;
      end
      PWR_RAMP: begin
        if (pwr.main_oc || pwr.aux_fault) n.st = PWR_FAULT;
        else if (!pwr.request) n.st = PWR_DRAIN;
        else if (pwr.gate_12v_high && pwr.gate_5v_3v_high) begin
          n.st = PWR_ON;
          n.status = 1'b1;
        end
      end
      PWR_ON: begin
        if (pwr.main_oc || pwr.aux_fault) n.st = PWR_FAULT;
        else if (!pwr.request) n.st = PWR_DRAIN;
      end
      PWR_DRAIN: begin
        // status stays up until the rails are really gone
        if (pwr.supplies_low) begin
          n.st = PWR_OFF;
          n.status = 1'b0;
        end
      end
      PWR_FAULT: begin
        n.status = 1'b0;
        n.fault = 1'b1;
        if (!pwr.request) begin
          n.st = PWR_OFF;
          n.fault = 1'b0;
        end
      end
      default: n.st = PWR_OFF;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) r <= '0;
    else r <= n;
  end

  assign pwr.gate_enable = (r.st == PWR_RAMP) || (r.st == PWR_ON);
  assign pwr.power_status = r.status;
  assign pwr.main_fault = r.fault;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_status_rise_gates: assert property ($rose(r.status) |-> $past(pwr.gate_12v_high) && $past(pwr.gate_5v_3v_high))
    else $error("power status rose before both gates were high");
  a_oc_drops_status: assert property ((r.st == PWR_ON) && pwr.main_oc |=> ##1 !r.status)
    else $error("power status not low after over-current");
  a_drain_low_only: assert property ($fell(r.status) && $past(r.st) == PWR_DRAIN |-> $past(pwr.supplies_low))
    else $error("power status fell before supplies were low");
  a_fault_clear: assert property ((r.st == PWR_FAULT) && !pwr.request |=> !r.fault)
    else $error("main fault not cleared on request removal");
  c_full_on: cover property (r.st == PWR_RAMP ##[1:1000] r.st == PWR_ON);
endmodule : main_power_sequencer

// >>> src/slot_power_if.sv
// carrier between the slot logic and the main power sequencer
`timescale 1ns/10ps
interface slot_power_if;
  logic request;
  logic gate_12v_high;
  logic gate_5v_3v_high;
  logic supplies_low;
  logic main_oc;
  logic aux_fault;
  logic gate_enable;
  logic power_status;
  logic main_fault;
  modport seq (input request, gate_12v_high, gate_5v_3v_high, supplies_low, main_oc, aux_fault,
               output gate_enable, power_status, main_fault);
  modport ctl (output request, gate_12v_high, gate_5v_3v_high, supplies_low, main_oc, aux_fault,
               input gate_enable, power_status, main_fault);
endinterface : slot_power_if
